// ===== core/itdc_defs.svh
`ifndef ITDC_DEFS_SVH
`define ITDC_DEFS_SVH
// system clock rate in Hz (40 MHz)
`define ITDC_CLK_HZ 50'h2625A00
// frequency band and set points in Hz
`define ITDC_F_MIN 18'h1ADB0
`define ITDC_F_MAX 18'h23668
`define ITDC_F_PING 18'h222E0
`define ITDC_F_FB_INIT 18'h23668
`define ITDC_SV_B1 18'h1C138
`define ITDC_SV_B2 18'h1D4C0
`define ITDC_SV_B3 18'h20F58
// scaling factors in tenths of Hz
`define ITDC_SV_1 8'hF
`define ITDC_SV_2 8'h14
`define ITDC_SV_3 8'h1E
`define ITDC_SV_4 8'h32
// duty cycle in tenths of a percent
`define ITDC_D_HALF 10'h1F4
`define ITDC_D_FB_MIN 10'h190
`define ITDC_D_TOP_MIN 10'h32
`define ITDC_D_FB_INIT 10'hC8
// contract power threshold in mW
`define ITDC_P_5W 16'h1388
// gains and limits, scaled by 100
`define ITDC_FB_KP 32'shC8
`define ITDC_FB_KI 32'sh1
`define ITDC_FB_KD 32'sh0
`define ITDC_FB_ILIM 32'shC350
`define ITDC_FB_OLIM 32'sh7A120
`define ITDC_HB_KP 32'sh1F4
`define ITDC_HB_KI 32'sh2
`define ITDC_HB_KD 32'sh0
`define ITDC_HB_ILIM 32'sh186A0
`define ITDC_HB_OLIM 32'shF4240
`define ITDC_SCALE_DIV 32'sh3E8
// register byte offsets
`define ITDC_ADR_CTRL 8'h00
`define ITDC_ADR_CONTRACT 8'h04
`define ITDC_ADR_TARGET 8'h08
`define ITDC_ADR_STATUS 8'h0C
`define ITDC_ADR_FREQ 8'h10
`define ITDC_ADR_DUTY 8'h14
`define ITDC_ADR_CURRENT 8'h18
// field positions
`define ITDC_CTRL_RUN 0
`define ITDC_ST_POWER 0
`define ITDC_ST_FB 1
`define ITDC_ST_TOP 2
`define ITDC_ST_BUSY 3
`define ITDC_ST_RES 4
`endif

// ===== core/itdc_pkg.sv
package itdc_pkg;
   // control states, one-hot
   typedef enum logic [3:0] {
      ITDC_IDLE = 4'h1,
      ITDC_POWER = 4'h2,
      ITDC_CALC = 4'h4,
      ITDC_APPLY = 4'h8
   } itdc_state_t;
   // one parameter set of the loop
   typedef struct packed {
      logic signed [31:0] kp;
      logic signed [31:0] ki;
      logic signed [31:0] kd;
      logic signed [31:0] ilim;
      logic signed [31:0] olim;
   } itdc_gain_t;
   // bridge gate drives
   typedef struct packed {
      logic a_hi;
      logic a_lo;
      logic b_hi;
      logic b_lo;
   } itdc_gate_t;
   // wishbone request and response
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } itdc_wb_req_t;
   typedef struct packed {
      logic ack;
      logic [31:0] dat;
   } itdc_wb_rsp_t;
endpackage

// ===== core/itdc_pwm.sv
`timescale 1ns/1ps
`default_nettype none
`include "itdc_defs.svh"
module itdc_pwm (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // settings
   input wire logic en_i,
   input wire logic fb_i,
   input wire logic [17:0] freq_i,
   input wire logic [9:0] duty_i,
   // gates
   output itdc_pkg::itdc_gate_t gate_o
);
   import itdc_pkg::*;
   logic [31:0] phase_q;
   logic [31:0] phase2;
   logic [49:0] inc_w;
   logic [19:0] thr_w;
   logic p1;
   logic p2;
   // phase increment in steps of about 0.0093 Hz (40 MHz / 2^32), far finer than needed
   assign inc_w = {freq_i, 32'h0} / `ITDC_CLK_HZ;
   // duty threshold in 1/1024 of a period
   assign thr_w = {duty_i, 10'h0} / 20'h3E8;
   assign phase2 = phase_q + 32'h80000000;
   assign p1 = phase_q[31:22] < thr_w[9:0];
   assign p2 = phase2[31:22] < thr_w[9:0];
   // phase accumulator
   always_ff @(posedge clk_i) begin
      if (rst_i || !en_i) begin
         phase_q <= 32'h0;
      end else begin
         phase_q <= phase_q + inc_w[31:0];
      end
   end
   // gate pattern per topology
   always_ff @(posedge clk_i) begin
      if (rst_i || !en_i) begin
         gate_o <= '0;
      end else if (fb_i) begin
         gate_o <= '{a_hi: p1, a_lo: p2, b_hi: p2, b_lo: p1};
      end else begin
         gate_o <= '{a_hi: p1, a_lo: !p1, b_hi: 1'b0, b_lo: 1'b1};
      end
   end
endmodule
`default_nettype wire

// ===== core/itdc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "itdc_defs.svh"
module itdc_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // register bus
   input wire itdc_pkg::itdc_wb_req_t wb_i,
   output itdc_pkg::itdc_wb_rsp_t wb_o,
   // coil current amplitude in mA
   input wire logic [11:0] coil_ma_i,
   // inverter and status
   output itdc_pkg::itdc_gate_t gate_o,
   output logic power_on_o,
   output logic full_bridge_o,
   output logic res_sense_cap_o
);
   import itdc_pkg::*;

   // saturate a signed value to plus or minus lim
   function automatic logic signed [31:0] sat(input logic signed [31:0] x,
                                              input logic signed [31:0] lim);
      if (x > lim) begin
         sat = lim;
      end else if (x < -lim) begin
         sat = -lim;
      end else begin
         sat = x;
      end
   endfunction

   // byte lane merge for writes
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [3:0] sel);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      merge = r;
   endfunction

   // band scaling in tenths of Hz
   function automatic logic [7:0] scale_of(input logic [17:0] f);
      if (f < `ITDC_SV_B1) begin
         scale_of = `ITDC_SV_1;
      end else if (f < `ITDC_SV_B2) begin
         scale_of = `ITDC_SV_2;
      end else if (f < `ITDC_SV_B3) begin
         scale_of = `ITDC_SV_3;
      end else begin
         scale_of = `ITDC_SV_4;
      end
   endfunction

   // register state
   logic ack_q;
   logic [31:0] rdat_q;
   logic run_q;
   logic [15:0] pmax_q;
   logic contract_q;
   logic [11:0] target_q;
   logic ce_pend_q;
   // current synchroniser
   logic [11:0] cur_s1_q;
   logic [11:0] cur_s2_q;
   logic [11:0] cur_p_q;
   logic [11:0] cur_q;
   // loop state
   itdc_state_t state_q;
   logic fb_q;
   logic [17:0] freq_q;
   logic [9:0] duty_q;
   logic signed [31:0] err_q;
   logic signed [31:0] eprev_q;
   logic signed [31:0] integ_q;
   logic power_q;
   logic fb_out_q;
   logic res_q;

   // bus decode
   logic req_w;
   logic wr_w;
   logic ce_ev_w;
   logic [31:0] rd_w;
   logic [31:0] status_w;
   assign req_w = wb_i.cyc && wb_i.stb && !ack_q;
   assign wr_w = req_w && wb_i.we;
   assign ce_ev_w = wr_w && (wb_i.adr == `ITDC_ADR_TARGET) && (wb_i.sel != 4'h0);

   // status word; resonance sensing always reads zero
   assign status_w = {27'h0, res_q, (ce_pend_q || state_q == ITDC_CALC ||
                      state_q == ITDC_APPLY), (freq_q == `ITDC_F_MAX), fb_q,
                      (state_q != ITDC_IDLE)};

   // read mux, unmapped addresses read zero
   assign rd_w = (wb_i.adr == `ITDC_ADR_CTRL) ? {31'h0, run_q} :
                 (wb_i.adr == `ITDC_ADR_CONTRACT) ? {16'h0, pmax_q} :
                 (wb_i.adr == `ITDC_ADR_TARGET) ? {20'h0, target_q} :
                 (wb_i.adr == `ITDC_ADR_STATUS) ? status_w :
                 (wb_i.adr == `ITDC_ADR_FREQ) ? {14'h0, freq_q} :
                 (wb_i.adr == `ITDC_ADR_DUTY) ? {22'h0, duty_q} :
                 (wb_i.adr == `ITDC_ADR_CURRENT) ? {20'h0, cur_q} : 32'h0;

   // bus handshake, one wait state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         rdat_q <= 32'h0;
      end else begin
         ack_q <= req_w;
         rdat_q <= req_w ? rd_w : 32'h0;
      end
   end
   assign wb_o = '{ack: ack_q, dat: rdat_q};

   // software registers
   logic [31:0] ctrl_m;
   logic [31:0] pmax_m;
   logic [31:0] tgt_m;
   assign ctrl_m = merge({31'h0, run_q}, wb_i.dat, wb_i.sel);
   assign pmax_m = merge({16'h0, pmax_q}, wb_i.dat, wb_i.sel);
   assign tgt_m = merge({20'h0, target_q}, wb_i.dat, wb_i.sel);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_q <= 1'b0;
         pmax_q <= 16'h0;
         target_q <= 12'h0;
      end else if (wr_w) begin
         if (wb_i.adr == `ITDC_ADR_CTRL) begin
            run_q <= ctrl_m[`ITDC_CTRL_RUN];
         end
         if (wb_i.adr == `ITDC_ADR_CONTRACT) begin
            pmax_q <= pmax_m[15:0];
         end
         if (wb_i.adr == `ITDC_ADR_TARGET) begin
            target_q <= tgt_m[11:0];
         end
      end
   end

   // current in 1 mA steps, two flops, taken once two samples agree
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cur_s1_q <= 12'h0;
         cur_s2_q <= 12'h0;
         cur_p_q <= 12'h0;
         cur_q <= 12'h0;
      end else begin
         cur_s1_q <= coil_ma_i;
         cur_s2_q <= cur_s1_q;
         cur_p_q <= cur_s2_q;
         cur_q <= (cur_s2_q == cur_p_q) ? cur_s2_q : cur_q;
      end
   end

   // gain set by topology
   itdc_gain_t g_w;
   assign g_w = fb_q ?
      itdc_gain_t'{kp: `ITDC_FB_KP, ki: `ITDC_FB_KI, kd: `ITDC_FB_KD,
        ilim: `ITDC_FB_ILIM, olim: `ITDC_FB_OLIM} :
      itdc_gain_t'{kp: `ITDC_HB_KP, ki: `ITDC_HB_KI, kd: `ITDC_HB_KD,
        ilim: `ITDC_HB_ILIM, olim: `ITDC_HB_OLIM};

   // loop arithmetic, all terms scaled by 100
   logic signed [31:0] err_w;
   logic signed [31:0] integ_w;
   logic signed [31:0] pid_w;
   logic [7:0] sv_w;
   logic signed [31:0] df_w;
   logic signed [31:0] dd_w;
   logic signed [31:0] fnew_w;
   logic signed [31:0] dnew_w;
   logic duty_mode_w;
   logic switch_w;
   assign err_w = $signed({20'h0, target_q}) - $signed({20'h0, cur_q});
   assign integ_w = sat(integ_q + 32'(g_w.ki * err_q), g_w.ilim);
   assign pid_w = sat(32'(g_w.kp * err_q) + integ_q +
                      32'(g_w.kd * (err_q - eprev_q)), g_w.olim);
   // 140-145 kHz falls in the top 5 Hz band
   assign sv_w = scale_of(freq_q);
   assign df_w = 32'(pid_w * $signed({24'h0, sv_w})) / `ITDC_SCALE_DIV;
   // duty moves by +0.01% per unit of loop output: more power, more duty
   assign dd_w = pid_w / `ITDC_SCALE_DIV;
   // positive output lowers frequency or raises duty
   assign fnew_w = sat($signed({14'h0, freq_q}) - df_w, 32'sh7FFFFFFF);
   assign dnew_w = $signed({22'h0, duty_q}) + dd_w;
   // duty is touched only at the top of the band
   assign duty_mode_w = (freq_q == `ITDC_F_MAX) &&
                        !(pid_w > 32'sh0 && duty_q == `ITDC_D_HALF);
   // first error after a large contract moves to full bridge
   assign switch_w = !fb_q && contract_q && (pmax_q > `ITDC_P_5W);

   // contract valid once written, cleared when power stops
   always_ff @(posedge clk_i) begin
      if (rst_i || state_q == ITDC_IDLE) begin
         contract_q <= 1'b0;
      end else if (wr_w && wb_i.adr == `ITDC_ADR_CONTRACT) begin
         contract_q <= 1'b1;
      end
   end

   // pending error report; a new report beats its own consumption
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ce_pend_q <= 1'b0;
      end else if (ce_ev_w) begin
         ce_pend_q <= 1'b1;
      end else if (state_q == ITDC_POWER || state_q == ITDC_IDLE) begin
         ce_pend_q <= 1'b0;
      end
   end

   // control sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ITDC_IDLE;
         fb_q <= 1'b0;
         freq_q <= `ITDC_F_PING;
         duty_q <= `ITDC_D_HALF;
         err_q <= 32'sh0;
         eprev_q <= 32'sh0;
         integ_q <= 32'sh0;
      end else begin
         case (state_q)
            ITDC_IDLE: begin
               if (run_q) begin
                  // ping in half bridge at 140 kHz, 50%
                  fb_q <= 1'b0;
                  freq_q <= `ITDC_F_PING;
                  duty_q <= `ITDC_D_HALF;
                  integ_q <= 32'sh0;
                  eprev_q <= 32'sh0;
                  state_q <= ITDC_POWER;
               end
            end
            ITDC_POWER: begin
               if (!run_q) begin
                  state_q <= ITDC_IDLE;
               end else if (ce_pend_q && switch_w) begin
                  // full bridge start at 145 kHz, 20%
                  fb_q <= 1'b1;
                  freq_q <= `ITDC_F_FB_INIT;
                  duty_q <= `ITDC_D_FB_INIT;
                  integ_q <= 32'sh0;
                  eprev_q <= 32'sh0;
               end else if (ce_pend_q) begin
                  state_q <= ITDC_CALC;
               end
            end
            ITDC_CALC: begin
               err_q <= err_w;
               state_q <= ITDC_APPLY;
            end
            ITDC_APPLY: begin
               integ_q <= integ_w;
               eprev_q <= err_q;
               state_q <= ITDC_POWER;
               if (duty_mode_w) begin
                  // at the top duty may fall to 5%
                  if (dnew_w > $signed({22'h0, `ITDC_D_HALF})) begin
                     duty_q <= `ITDC_D_HALF;
                  end else if (dnew_w < $signed({22'h0, `ITDC_D_TOP_MIN})) begin
                     duty_q <= `ITDC_D_TOP_MIN;
                  end else begin
                     duty_q <= dnew_w[9:0];
                  end
               end else begin
                  // below the top the duty stays at 50%
                  duty_q <= `ITDC_D_HALF;
                  // frequency kept in the band
                  if (fnew_w > $signed({14'h0, `ITDC_F_MAX})) begin
                     freq_q <= `ITDC_F_MAX;
                  end else if (fnew_w < $signed({14'h0, `ITDC_F_MIN})) begin
                     freq_q <= `ITDC_F_MIN;
                  end else begin
                     freq_q <= fnew_w[17:0];
                  end
               end
            end
            default: begin
               state_q <= ITDC_IDLE;
            end
         endcase
      end
   end

   // registered status outputs; capability flag held clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         power_q <= 1'b0;
         fb_out_q <= 1'b0;
         res_q <= 1'b0;
      end else begin
         power_q <= (state_q != ITDC_IDLE);
         fb_out_q <= fb_q;
         res_q <= 1'b0;
      end
   end
   assign power_on_o = power_q;
   assign full_bridge_o = fb_out_q;
   assign res_sense_cap_o = res_q;

   // inverter drive
   itdc_pwm u_pwm (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .en_i(state_q != ITDC_IDLE),
      .fb_i(fb_q),
      .freq_i(freq_q),
      .duty_i(duty_q),
      .gate_o(gate_o)
   );

   // checks
   chk_freq_band: assert property (@(posedge clk_i) disable iff (rst_i)
      freq_q >= `ITDC_F_MIN && freq_q <= `ITDC_F_MAX)
      else $error("frequency left the band");
   chk_fb_duty: assert property (@(posedge clk_i) disable iff (rst_i)
      (fb_q && freq_q != `ITDC_F_MAX) |-> duty_q >= `ITDC_D_FB_MIN &&
      duty_q <= `ITDC_D_HALF)
      else $error("full bridge duty out of range");
   chk_top_duty: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == ITDC_APPLY) |=> duty_q >= `ITDC_D_TOP_MIN)
      else $error("duty below minimum");
   chk_power_dir: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == ITDC_APPLY && pid_w > 32'sh0 && !duty_mode_w) |=>
      freq_q <= $past(freq_q))
      else $error("more power raised frequency");
   chk_ping_start: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == ITDC_IDLE && run_q) |=> !fb_q && freq_q == `ITDC_F_PING &&
      duty_q == `ITDC_D_HALF ##1 power_on_o)
      else $error("ping settings wrong");
   chk_fb_switch: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == ITDC_POWER && run_q && ce_pend_q && switch_w) |=>
      fb_q && freq_q == `ITDC_F_FB_INIT && duty_q == `ITDC_D_FB_INIT ##1 full_bridge_o)
      else $error("full bridge switch wrong");
   chk_loop_seq: assert property (@(posedge clk_i) disable iff (rst_i)
      (state_q == ITDC_POWER && run_q && ce_pend_q && !switch_w) |=>
      state_q == ITDC_CALC ##1 state_q == ITDC_APPLY ##1 state_q == ITDC_POWER)
      else $error("loop step sequence broken");
   chk_gain_set: assert property (@(posedge clk_i) disable iff (rst_i)
      fb_q ? (g_w.kp == `ITDC_FB_KP && g_w.olim == `ITDC_FB_OLIM) :
      (g_w.kp == `ITDC_HB_KP && g_w.olim == `ITDC_HB_OLIM))
      else $error("wrong gain set");
   chk_integ_lim: assert property (@(posedge clk_i) disable iff (rst_i)
      fb_q ? (integ_q <= `ITDC_FB_ILIM && integ_q >= -`ITDC_FB_ILIM) :
      (integ_q <= `ITDC_HB_ILIM && integ_q >= -`ITDC_HB_ILIM))
      else $error("integral term over its limit");
   chk_scale_top: assert property (@(posedge clk_i) disable iff (rst_i)
      (freq_q >= `ITDC_SV_B3 |-> sv_w == `ITDC_SV_4) and
      (freq_q < `ITDC_SV_B1 |-> sv_w == `ITDC_SV_1))
      else $error("wrong band scaling");
   chk_cap_clear: assert property (@(posedge clk_i) disable iff (rst_i)
      !res_sense_cap_o && !status_w[`ITDC_ST_RES])
      else $error("capability flag set");
   chk_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      ack_q |=> !ack_q)
      else $error("ack longer than one cycle");
endmodule
`default_nettype wire

// ===== testbench/itdc_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module itdc_rx_model (
   // clock
   input wire logic clk_i,
   // amplitude the receiver load should draw, in mA
   input wire logic [11:0] level_i,
   // sensed coil current amplitude
   output logic [11:0] coil_ma_o
);
   // level moves only just after an edge and then stays put
   always_ff @(posedge clk_i) begin
      coil_ma_o <= level_i;
   end
endmodule
`default_nettype wire

// ===== testbench/inductive_tx_drive_control_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "itdc_defs.svh"
module inductive_tx_drive_control_tb_top;
   import itdc_pkg::*;
   typedef struct {int kind; int lo; int hi;} itdc_note_t;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   itdc_wb_req_t wb_q = '0;
   itdc_wb_rsp_t wb_o;
   logic [11:0] lvl_q = 12'h0;
   logic [11:0] coil_ma;
   itdc_gate_t gate_o;
   logic power_on_o, full_bridge_o, res_sense_cap_o;
   logic [31:0] rd;
   itdc_note_t notes[$];
   int bad_count = 0;
   int tests_run = 0;
   int cyc_n = 0;
   int m_f, m_d, m_i, m_fb, m_cv, m_pmax;

   // block under test and receiver load
   itdc_top u_itdc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_q), .wb_o(wb_o),
      .coil_ma_i(coil_ma), .gate_o(gate_o), .power_on_o(power_on_o),
      .full_bridge_o(full_bridge_o), .res_sense_cap_o(res_sense_cap_o));
   itdc_rx_model u_itdc_rx_model (.clk_i(clk_i), .level_i(lvl_q), .coil_ma_o(coil_ma));

   // 40 MHz clock
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   // hang guard
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 80000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   task automatic chk_eq(input logic [31:0] act, input int exp);
      tests_run++;
      if (act !== 32'(exp)) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, act, exp);
      end
   endtask

   task automatic chk_rng(input logic [31:0] act, input int lo, input int hi);
      tests_run++;
      if ((act >= 32'(lo) && act <= 32'(hi)) !== 1'b1) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%0h exp=%0h..%0h", $time, act, lo, hi);
      end
   endtask

   // pairs each acknowledged cycle with the oldest note
   always @(posedge clk_i) begin
      itdc_note_t n;
      if (wb_o.ack === 1'b1 && notes.size() > 0) begin
         n = notes.pop_front();
         if (n.kind == 1) chk_eq(wb_o.dat, n.lo);
         if (n.kind == 2) chk_rng(wb_o.dat, n.lo, n.hi);
      end
   end

   // one classic cycle, held until ack, then one idle cycle
   task automatic wb(input logic we, input logic [7:0] adr, input int dat, input int kind,
                     input int lo, input int hi);
      notes.push_back('{kind, lo, hi});
      wb_q <= '{1'b1, 1'b1, we, adr, 4'hF, 32'(dat)};
      @(posedge clk_i);
      while (wb_o.ack !== 1'b1) begin
         @(posedge clk_i);
      end
      rd = wb_o.dat;
      wb_q <= '0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input int d);
      wb(1'b1, a, d, 0, 0, 0);
   endtask

   task automatic rd_eq(input logic [7:0] a, input int e);
      wb(1'b0, a, 0, 1, e, e);
   endtask

   // waits until no report is pending
   task automatic settle();
      int k;
      k = 0;
      do begin
         wb(1'b0, `ITDC_ADR_STATUS, 0, 0, 0, 0);
         k++;
      end while (rd[`ITDC_ST_BUSY] !== 1'b0 && k < 20);
      if (k >= 20) bad_count++;
   endtask

   function automatic int sat(int v, int l);
      return v > l ? l : (v < -l ? -l : v);
   endfunction

   // one error report; expected loop outcome reckoned alongside
   task automatic report(input int tgt, input int cur);
      int err, o, sv;
      lvl_q <= 12'(cur);
      repeat (6) @(posedge clk_i);
      wr(`ITDC_ADR_TARGET, tgt);
      settle();
      err = tgt - cur;
      if (m_fb == 0 && m_cv == 1 && m_pmax > 5000) begin
         m_fb = 1;
         m_f = 145000;
         m_d = 200;
         m_i = 0;
      end else begin
         o = (m_fb ? 200 : 500) * err + m_i;
         m_i = sat(m_i + (m_fb ? 1 : 2) * err, m_fb ? 50000 : 100000);
         o = sat(o, m_fb ? 500000 : 1000000);
         if (m_f == 145000 && !(o > 0 && m_d == 500)) begin
            m_d = m_d + o / 1000;
            m_d = m_d > 500 ? 500 : (m_d < 50 ? 50 : m_d);
         end else begin
            sv = m_f < 115000 ? 15 : m_f < 120000 ? 20 : m_f < 135000 ? 30 : 50;
            m_f = m_f - o * sv / 1000;
            m_f = m_f > 145000 ? 145000 : (m_f < 110000 ? 110000 : m_f);
            m_d = 500;
         end
      end
      rd_eq(`ITDC_ADR_CURRENT, cur);
      rd_eq(`ITDC_ADR_FREQ, m_f);
      rd_eq(`ITDC_ADR_DUTY, m_d);
      wb(1'b0, `ITDC_ADR_FREQ, 0, 2, 110000, 145000);
      if (m_fb) wb(1'b0, `ITDC_ADR_DUTY, 0, 2, m_f == 145000 ? 50 : 400, 500);
      rd_eq(`ITDC_ADR_STATUS, 1 + 2 * m_fb + 4 * (m_f == 145000));
   endtask

   // duty and rate seen on the high-side gate over 100 us
   task automatic measure(input int duty, input int freq);
      int hi, rise;
      logic prev;
      hi = 0;
      rise = 0;
      prev = gate_o.a_hi;
      repeat (4000) begin
         @(posedge clk_i);
         hi += int'(gate_o.a_hi === 1'b1);
         rise += int'(gate_o.a_hi === 1'b1 && prev === 1'b0);
         prev = gate_o.a_hi;
      end
      chk_rng(hi, duty * 4 - 300, duty * 4 + 300);
      chk_rng(rise, freq / 10000 - 1, freq / 10000 + 1);
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      void'($urandom(32'h68d732e0));
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd_eq(`ITDC_ADR_STATUS, 0);
      wr(8'h1C, 32'h5A5A);
      rd_eq(8'h1C, 0);
      wr(`ITDC_ADR_CTRL, 1);
      m_f = 140000;
      m_d = 500;
      m_i = 0;
      m_fb = 0;
      m_cv = 0;
      m_pmax = 0;
      wb(1'b0, `ITDC_ADR_FREQ, 0, 2, 135000, 145000);
      rd_eq(`ITDC_ADR_DUTY, 500);
      chk_eq({power_on_o, full_bridge_o, res_sense_cap_o}, 4);
      measure(500, 140000);
      chk_eq({gate_o.b_hi, gate_o.b_lo}, 1);
      report(100, 110);
      report(100, 110);
      report(0, 4000);
      report(0, 4000);
      report(4000, 0);
      repeat (16) report(int'($urandom_range(400)), int'($urandom_range(400)));
      wr(`ITDC_ADR_CONTRACT, 5000);
      m_cv = 1;
      m_pmax = 5000;
      report(300, 300);
      wr(`ITDC_ADR_CONTRACT, 5001);
      m_pmax = 5001;
      report(300, 300);
      measure(200, 145000);
      report(0, 4000);
      repeat (16) report(int'($urandom_range(400)), int'($urandom_range(400)));
      wr(`ITDC_ADR_CTRL, 0);
      repeat (4) @(posedge clk_i);
      // idle keeps the last topology and frequency until the next start
      chk_eq({power_on_o, full_bridge_o, res_sense_cap_o, gate_o}, 32 * m_fb);
      wr(`ITDC_ADR_TARGET, 5);
      rd_eq(`ITDC_ADR_STATUS, 2 * m_fb + 4 * (m_f == 145000));
      wr(`ITDC_ADR_CTRL, 1);
      rd_eq(`ITDC_ADR_STATUS, 1);
      wb(1'b0, `ITDC_ADR_FREQ, 0, 2, 135000, 145000);
      rd_eq(`ITDC_ADR_DUTY, 500);
      // reset in mid-run while powered
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd_eq(`ITDC_ADR_STATUS, 0);
      rd_eq(`ITDC_ADR_FREQ, 140000);
      chk_eq({power_on_o, full_bridge_o, res_sense_cap_o, gate_o}, 0);
      tally_and_finish();
   end
endmodule
`default_nettype wire
